/* wic_pkg.sv */
/*
  Constants shared by the wake-up and interrupt controller: register
  offsets, bit positions, vectors, response codes and power modes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package wic_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_MASK   = 5'h00;
  localparam logic [4:0] OFS_FLAG   = 5'h04;
  localparam logic [4:0] OFS_WAKE   = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_PORT   = 5'h10;
  localparam int         ADDR_W     = 5;

  // Event bit positions, shared by mask and pending flags
  localparam int BIT_OVF  = 0;
  localparam int BIT_PIN  = 1;
  localparam int BIT_CMP  = 2;
  localparam int BIT_EXT  = 3;
  localparam int BIT_PWM  = 4;
  localparam int NUM_EV   = 5;

  // Wake control bit positions
  localparam int WK_PIN   = 1;
  localparam int WK_CMP   = 2;

  // Reset values
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [2:0] WAKE_RST = 3'h0;

  // Branch targets
  localparam logic [7:0] VEC_EXT  = 8'h03;
  localparam logic [7:0] VEC_PIN  = 8'h06;
  localparam logic [7:0] VEC_OVF  = 8'h09;
  localparam logic [7:0] VEC_CMP  = 8'h0C;
  localparam logic [7:0] VEC_PWM  = 8'h0F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SLEEP  = 3'b010,
    MODE_IDLE   = 3'b100
  } wic_mode_t;

endpackage : wic_pkg

/* wic_ctrl.sv */
/*
  Wake-up and interrupt controller of a small 8-bit core, with its
  registers on an AXI4-Lite slave. Decides per power mode whether an
  event wakes the core, sets its pending flag, and whether the core
  branches to a vector or resumes at the next instruction.
  Assumes the core sequencer gives one-cycle pulses for its sleep,
  idle and global enable/disable instructions, and that all event
  inputs are synchronous to aclk.
*/
// Behaviour
// - Wake from sleep and idle on qualifying events
// - Enabled source after wake, global on, branches to its vector
// - Disabled source after wake resumes next instruction
// - Overflow, enabled, global on: flag, vector 0x09
// - Overflow, enabled, global off: flag, continue
// - Sleep, pin wake/irq off: no wake, no flag
// - Sleep, irq only: set flag, stay asleep
// - Sleep, wake only: wake, resume, no flag
// - Sleep, wake+irq, global off: wake, flag, resume
// - Sleep, wake+irq+global: wake, flag, vector 0x06
// - Normal, pin irq off: no flag, no interrupt
// - Normal, pin irq, global off: flag, continue
// - Normal, pin irq, global on: flag, vector 0x06
// - External pin, enabled, global on: vector 0x03
// - External pin, enabled, global off: flag only
// - Oscillator and timers stopped while sleeping
`timescale 1ns/1ps
module wic_ctrl #(
  parameter int P6_W = 8
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [wic_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // AXI4-Lite write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read
  input  wire logic [wic_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Core sequencer
  input  wire logic                       sleep_instruction,
  input  wire logic                       idle_instruction,
  input  wire logic                       global_irq_on,
  input  wire logic                       global_irq_off,
  output logic                            vector_valid,
  output logic [7:0]                      vector_addr,
  output logic                            resume_next,
  output logic                            osc_run,
  output logic                            reset_req,
  // Event sources
  input  wire logic [P6_W-1:0]            port6_in,
  input  wire logic                       ext_pin_n,
  input  wire logic                       timer_overflow,
  input  wire logic                       comparator_change,
  input  wire logic                       period_match,
  input  wire logic                       watchdog_timeout,
  input  wire logic                       low_voltage
);
  import wic_pkg::*;

  if (P6_W < 1 || P6_W > 32) begin : g_bad_width
    $error("P6_W must be 1 to 32");
  end

  typedef struct packed {
    wic_mode_t          mode;
    logic               gie;
    logic [NUM_EV-1:0]  mask;
    logic [NUM_EV-1:0]  flags;
    logic [2:0]         wake;
    logic [P6_W-1:0]    p6_prev;
    logic               ext_prev;
    logic               vec_valid;
    logic [7:0]         vec_addr;
    logic               resume;
    logic               osc;
    logic               rst_req;
    logic               aw_rdy;
    logic               w_rdy;
    logic               aw_got;
    logic               w_got;
    logic [ADDR_W-1:0]  aw_addr;
    logic [7:0]         w_byte;
    logic               w_lane;
    logic               b_valid;
    logic [1:0]         b_resp;
    logic               ar_rdy;
    logic               r_valid;
    logic [1:0]         r_resp;
    logic [31:0]        r_data;
  } wic_state_t;

  wic_state_t st_reg;
  wic_state_t st_next;

  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] hit;
  logic [NUM_EV-1:0] wakes;
  logic              wr_do;
  logic              any_reset;

  // Port change against the previous sample; external pin acts on fall
  always_comb begin
    ev           = '0;
    ev[BIT_OVF]  = timer_overflow;
    ev[BIT_PIN]  = |(port6_in ^ st_reg.p6_prev);
    ev[BIT_CMP]  = comparator_change;
    ev[BIT_EXT]  = st_reg.ext_prev & ~ext_pin_n;
    ev[BIT_PWM]  = period_match;
  end

  assign hit       = ev & st_reg.mask;
  assign wr_do     = st_reg.aw_got & st_reg.w_got & ~st_reg.b_valid;
  assign any_reset = watchdog_timeout | low_voltage;

  // Which events may wake the core in the present mode
  always_comb begin
    wakes = '0;
    if (st_reg.mode == MODE_IDLE) begin
      wakes = ev;
      wakes[BIT_PIN] = ev[BIT_PIN] & st_reg.wake[WK_PIN];
      wakes[BIT_CMP] = ev[BIT_CMP] & st_reg.wake[WK_CMP];
    end else if (st_reg.mode == MODE_SLEEP) begin
      // Timers stand still, so only pin and comparator can act
      wakes[BIT_PIN] = ev[BIT_PIN] & st_reg.wake[WK_PIN];
      wakes[BIT_CMP] = ev[BIT_CMP] & st_reg.wake[WK_CMP];
    end
  end

  // Fixed priority: lowest vector address wins
  function automatic logic [7:0] wic_pick(input logic [NUM_EV-1:0] h);
    logic [7:0] v;
    v = VEC_PWM;
    if (h[BIT_CMP]) v = VEC_CMP;
    if (h[BIT_OVF]) v = VEC_OVF;
    if (h[BIT_PIN]) v = VEC_PIN;
    if (h[BIT_EXT]) v = VEC_EXT;
    return v;
  endfunction : wic_pick

  always_comb begin
    logic [NUM_EV-1:0] set;
    logic [NUM_EV-1:0] fire;
    st_next           = st_reg;
    set               = '0;
    fire              = '0;
    st_next.p6_prev   = port6_in;
    st_next.ext_prev  = ext_pin_n;
    st_next.vec_valid = 1'b0;
    st_next.resume    = 1'b0;
    st_next.rst_req   = 1'b0;

    if (global_irq_on) st_next.gie = 1'b1;
    if (global_irq_off) st_next.gie = 1'b0;

    unique case (st_reg.mode)
      MODE_NORMAL: begin
        set  = hit;
        fire = st_reg.gie ? hit : '0;
        if (|fire) begin
          st_next.vec_valid = 1'b1;
          st_next.vec_addr  = wic_pick(fire);
        end
        if (sleep_instruction) st_next.mode = MODE_SLEEP;
        else if (idle_instruction) st_next.mode = MODE_IDLE;
      end
      MODE_SLEEP, MODE_IDLE: begin
        // Pin flag may set without waking the core
        set = hit;
        if (st_reg.mode == MODE_SLEEP) begin
          set = hit & NUM_EV'((1 << BIT_PIN) | (1 << BIT_CMP));
        end
        if (|wakes) begin
          st_next.mode = MODE_NORMAL;
          fire = (st_reg.gie ? set : '0) & wakes;
          if (|fire) begin
            st_next.vec_valid = 1'b1;
            st_next.vec_addr  = wic_pick(fire);
          end else begin
            st_next.resume = 1'b1;
          end
        end
      end
    endcase

    // Watchdog and low voltage reset the core, never interrupt
    if (any_reset) begin
      st_next.mode      = MODE_NORMAL;
      st_next.rst_req   = 1'b1;
      st_next.vec_valid = 1'b0;
      st_next.resume    = 1'b0;
    end
    st_next.osc = (st_next.mode != MODE_SLEEP);

    // Write channel: address and data in either order
    if (awvalid && st_reg.aw_rdy) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_rdy  = 1'b0;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.w_rdy) begin
      st_next.w_got  = 1'b1;
      st_next.w_rdy  = 1'b0;
      st_next.w_byte = wdata[7:0];
      st_next.w_lane = wstrb[0];
    end
    st_next.flags = st_reg.flags;
    if (wr_do) begin
      st_next.b_valid = 1'b1;
      st_next.b_resp  = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFS_MASK: if (st_reg.w_lane)
          st_next.mask = st_reg.w_byte[NUM_EV-1:0];
        OFS_FLAG: if (st_reg.w_lane)
          st_next.flags = st_reg.flags & st_reg.w_byte[NUM_EV-1:0];
        OFS_WAKE: if (st_reg.w_lane) begin
          st_next.wake[WK_PIN] = st_reg.w_byte[WK_PIN];
          st_next.wake[WK_CMP] = st_reg.w_byte[WK_CMP];
        end
        OFS_STATUS, OFS_PORT: ;
        default: st_next.b_resp = RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    st_next.flags = st_next.flags | set;
    if (st_reg.b_valid && bready) begin
      st_next.b_valid = 1'b0;
      st_next.aw_got  = 1'b0;
      st_next.w_got   = 1'b0;
      st_next.aw_rdy  = 1'b1;
      st_next.w_rdy   = 1'b1;
    end

    // Read channel
    if (arvalid && st_reg.ar_rdy) begin
      st_next.ar_rdy  = 1'b0;
      st_next.r_valid = 1'b1;
      st_next.r_resp  = RESP_OKAY;
      st_next.r_data  = '0;
      unique case (araddr)
        OFS_MASK:   st_next.r_data[NUM_EV-1:0] = st_reg.mask;
        OFS_FLAG:   st_next.r_data[NUM_EV-1:0] = st_reg.flags;
        OFS_WAKE:   st_next.r_data[2:0] = st_reg.wake;
        OFS_STATUS: st_next.r_data[3:0] = {st_reg.gie, st_reg.mode};
        OFS_PORT:   st_next.r_data[P6_W-1:0] = port6_in;
        default:    st_next.r_resp = RESP_SLVERR;
      endcase
    end
    if (st_reg.r_valid && rready) begin
      st_next.r_valid = 1'b0;
      st_next.ar_rdy  = 1'b1;
    end
    st_next.wake[0] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.mode     <= MODE_NORMAL;
      st_reg.mask     <= MASK_RST;
      st_reg.flags    <= FLAG_RST;
      st_reg.wake     <= WAKE_RST;
      st_reg.ext_prev <= 1'b1;
      st_reg.osc      <= 1'b1;
      st_reg.aw_rdy   <= 1'b1;
      st_reg.w_rdy    <= 1'b1;
      st_reg.ar_rdy   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready      = st_reg.aw_rdy;
  assign wready       = st_reg.w_rdy;
  assign bvalid       = st_reg.b_valid;
  assign bresp        = st_reg.b_resp;
  assign arready      = st_reg.ar_rdy;
  assign rvalid       = st_reg.r_valid;
  assign rresp        = st_reg.r_resp;
  assign rdata        = st_reg.r_data;
  assign vector_valid = st_reg.vec_valid;
  assign vector_addr  = st_reg.vec_addr;
  assign resume_next  = st_reg.resume;
  assign osc_run      = st_reg.osc;
  assign reset_req    = st_reg.rst_req;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic normal;
  logic asleep;
  assign normal = (st_reg.mode == MODE_NORMAL) && !any_reset;
  assign asleep = (st_reg.mode == MODE_SLEEP) && !any_reset;

  a_ovf_vector: assert property (normal && hit[BIT_OVF] && st_reg.gie
    && !hit[BIT_EXT] && !hit[BIT_PIN]
    |=> vector_valid && vector_addr == VEC_OVF
    && st_reg.flags[BIT_OVF])
    else $error("overflow did not branch to its vector");
  a_ovf_no_branch: assert property (normal && hit[BIT_OVF]
    && !st_reg.gie && !global_irq_on
    |=> !vector_valid && st_reg.flags[BIT_OVF])
    else $error("overflow with global off misbehaved");
  a_pin_ignored: assert property (asleep && ev[BIT_PIN]
    && !st_reg.wake[WK_PIN] && !st_reg.mask[BIT_PIN]
    && !comparator_change
    |=> st_reg.mode == MODE_SLEEP && !resume_next)
    else $error("disabled pin change woke the core");
  a_pin_flag_sleep: assert property (asleep && ev[BIT_PIN]
    && !st_reg.wake[WK_PIN] && st_reg.mask[BIT_PIN]
    && !comparator_change
    |=> st_reg.flags[BIT_PIN] && !osc_run)
    else $error("pin flag not set while asleep");
  a_pin_wake_only: assert property (asleep && ev[BIT_PIN]
    && st_reg.wake[WK_PIN] && !st_reg.mask[BIT_PIN]
    && !hit[BIT_CMP]
    |=> resume_next && osc_run && !vector_valid)
    else $error("pin wake did not resume");
  a_pin_wake_vec: assert property (asleep && ev[BIT_PIN]
    && st_reg.wake[WK_PIN] && st_reg.mask[BIT_PIN] && st_reg.gie
    |=> vector_valid && vector_addr == VEC_PIN)
    else $error("pin wake did not branch");
  a_ext_vector: assert property (normal && hit[BIT_EXT] && st_reg.gie
    |=> vector_valid && vector_addr == VEC_EXT)
    else $error("external pin did not branch");
  a_reset_req: assert property (any_reset
    |=> reset_req && !vector_valid && st_reg.mode == MODE_NORMAL)
    else $error("watchdog or low voltage did not reset");
  a_sleep_osc: assert property (st_reg.mode == MODE_SLEEP
    |-> !osc_run)
    else $error("oscillator running in sleep");
  a_sleep_entry: assert property (normal && sleep_instruction
    |=> st_reg.mode == MODE_SLEEP && !osc_run)
    else $error("sleep pulse did not stop the oscillator");

  c_sleep_vector: cover property (asleep ##1 vector_valid);
  c_sleep_resume: cover property (asleep ##1 resume_next);
  c_idle_wake:    cover property (st_reg.mode == MODE_IDLE ##1 normal);
  c_normal_vec:   cover property (normal ##1 vector_valid);

endmodule : wic_ctrl

/* wic_src_model.sv */
/*
  Model of the core sequencer and event sources facing wic_ctrl.
  A one-cycle command strobe becomes the matching one-cycle pulse.
  Assumes the bench changes cmd and go just after a rising edge.
*/
`timescale 1ns/1ps
module wic_src_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench command
  input  wire logic [3:0] cmd,
  input  wire logic       go,
  input  wire logic [7:0] flip,
  // Core and event side
  output logic            sleep_instruction,
  output logic            idle_instruction,
  output logic            global_irq_on,
  output logic            global_irq_off,
  output logic            timer_overflow,
  output logic            ext_pin_n,
  output logic            watchdog_timeout,
  output logic            low_voltage,
  output logic            comparator_change,
  output logic            period_match,
  output logic [7:0]      port6_in
);
  // Outputs settle at the first edge, well inside the reset hold
  always @(posedge aclk) begin
    sleep_instruction <= go && cmd == 4'h0;
    idle_instruction  <= go && cmd == 4'h1;
    global_irq_on     <= go && cmd == 4'h2;
    global_irq_off    <= go && cmd == 4'h3;
    timer_overflow    <= go && cmd == 4'h4;
    // Low for one cycle: one falling edge per command
    ext_pin_n         <= !(go && cmd == 4'h6);
    watchdog_timeout  <= go && cmd == 4'h7;
    low_voltage       <= go && cmd == 4'h8;
    comparator_change <= go && cmd == 4'h9;
    period_match      <= go && cmd == 4'ha;
    // Zero after reset, else the first cycle counts as a change
    if (!aresetn)
      port6_in <= 8'h00;
    else if (go && cmd == 4'h5)
      port6_in <= port6_in ^ flip;
  end
endmodule : wic_src_model

/* wakeup_interrupt_control_tb.sv */
/*
  Self-checking bench for wic_ctrl: AXI4-Lite master tasks and event
  trials in normal, sleep and idle modes against an integer model.
  Assumes wic_src_model drives the core and event inputs.
*/
`timescale 1ns/1ps
module wakeup_interrupt_control_tb;
  import wic_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00;
  logic [4:0]  araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic [3:0]  cmd = 4'h0;
  logic [7:0]  flip = 8'h01;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        vector_valid, resume_next, osc_run, reset_req;
  logic [7:0]  vector_addr, port6_in;
  logic        sleep_instruction, idle_instruction, global_irq_on;
  logic        global_irq_off, timer_overflow, ext_pin_n;
  logic        watchdog_timeout, low_voltage;
  logic        comparator_change, period_match;
  logic [1:0]  r;
  logic [31:0] d;
  int          fails = 0;
  int          n_checks = 0;

  always #25 aclk = ~aclk;

  wic_ctrl wic_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sleep_instruction, .idle_instruction, .global_irq_on,
    .global_irq_off, .vector_valid, .vector_addr, .resume_next, .osc_run,
    .reset_req, .port6_in, .ext_pin_n, .timer_overflow,
    .comparator_change, .period_match, .watchdog_timeout,
    .low_voltage);

  wic_src_model wic_src_model_inst (.aclk, .aresetn, .cmd, .go, .flip,
    .sleep_instruction, .idle_instruction, .global_irq_on,
    .global_irq_off, .timer_overflow, .ext_pin_n, .watchdog_timeout,
    .low_voltage, .comparator_change, .period_match, .port6_in);

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic cmp_out(input logic [7:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp_out

  task automatic cmp_reg(input logic [33:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic axw(input logic [4:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
    int i;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    rs = bresp;
    bready <= 1'b0;
    if (i == 50) begin
      fails++;
      results();
    end
  endtask : axw

  task automatic axr(input logic [4:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (i == 50) begin
      fails++;
      results();
    end
  endtask : axr

  // Outputs of the event are settled 1 ns after the sampling edge
  task automatic fire(input logic [3:0] c);
    @(posedge aclk);
    cmd <= c;
    go <= 1'b1;
    flip <= 8'($urandom_range(255, 1));
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : fire

  task automatic trial(input int m, b, mb, w, g);
    logic [4:0] msk;
    logic [7:0] va;
    int         fl, wk, br, wb;
    msk = 5'($urandom) & ~(5'h01 << b) | 5'(mb << b);
    // Only pin and comparator have a wake bit of their own
    wb = b == 1 || b == 2;
    va = b == 0 ? VEC_OVF : b == 1 ? VEC_PIN : b == 2 ? VEC_CMP :
         b == 3 ? VEC_EXT : VEC_PWM;
    if (m == 1) begin
      axr(OFS_PORT, d, r);
      cmp_reg({r, d}, {RESP_OKAY, 24'h00_0000, port6_in});
    end
    axw(OFS_MASK, {24'($urandom), 3'h0, msk}, r);
    axw(OFS_WAKE, {24'($urandom), 5'h00, 1'(w != 0 && b == 2),
                   1'(w != 0 && b != 2), 1'b0}, r);
    axw(OFS_FLAG, 32'h0000_0000, r);
    fire(g != 0 ? 4'h2 : 4'h3);
    if (m == 1) fire(4'h0);
    if (m == 1) cmp_out(8'(osc_run), 8'h00, "osc");
    if (m == 2) fire(4'h1);
    fire(b == 0 ? 4'h4 : b == 1 ? 4'h5 : b == 2 ? 4'h9 :
         b == 3 ? 4'h6 : 4'ha);
    fl = mb != 0 && !(m == 1 && wb == 0);
    wk = m == 2 ? (wb == 0 || w != 0) : m == 1 ? (wb != 0 && w != 0) : 0;
    br = g != 0 && mb != 0 && (m == 0 || wk != 0);
    cmp_out(8'(vector_valid), 8'(br), "vec");
    cmp_out(8'(resume_next), 8'(wk && !br), "res");
    cmp_out(8'(osc_run), 8'(!(m == 1 && wk == 0)), "osc");
    if (br != 0)
      cmp_out(vector_addr, va, "addr");
    @(posedge aclk);
    axr(OFS_FLAG, d, r);
    cmp_reg({r, d}, 34'(fl << b));
    if (m != 0 && wk == 0) begin
      fire(4'($urandom_range(8, 7)));
      cmp_out(8'(reset_req), 8'h01, "rst");
      axr(OFS_STATUS, d, r);
      cmp_reg({r, 29'h0, d[2:0]}, {RESP_OKAY, 32'h1});
      axr(OFS_FLAG, d, r);
      cmp_reg({r, d}, 34'(fl << b));
    end
  endtask : trial

  initial begin
    void'($urandom(32'h3ccf985a));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axr(5'(i * 4), d, r);
      cmp_reg({r, d}, {i == 5 ? RESP_SLVERR : RESP_OKAY, 32'(i == 3)});
    end
    axw(5'h14, 32'h0000_001f, r);
    cmp_reg({r, 32'h0}, {RESP_SLVERR, 32'h0});
    for (int k = 0; k < 16; k++)
      trial(1, 1 + k / 8, k % 2, k / 2 % 2, k / 4 % 2);
    for (int k = 0; k < 40; k++)
      trial(k / 20 * 2, k % 5, k / 5 % 2,
            $urandom % 2, k / 10 % 2);
    results();
  end
endmodule : wakeup_interrupt_control_tb
